// File: design/gsr_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  bus status reporting block. Assumes a 32-bit APB with word-aligned registers.
*/
`ifndef GSR_REGS_SVH
`define GSR_REGS_SVH
// ----------------------------------------
// Offsets (byte addresses)
// ----------------------------------------
`define GSR_OFF_ADDR_STATUS 12'h000
`define GSR_OFF_EVENT_ONE 12'h004
`define GSR_OFF_EVENT_TWO 12'h008
`define GSR_OFF_OUT_TERM0 12'h010
`define GSR_OFF_IN_TERM0 12'h020
`define GSR_OFF_TERM_FLAGS0 12'h030
`define GSR_OFF_IO_TIMEOUT 12'h040
`define GSR_OFF_DMA_TIMEOUT 12'h044
`define GSR_OFF_MASK_ONE 12'h048
`define GSR_OFF_MASK_TWO 12'h04C
// ----------------------------------------
// Field positions
// ----------------------------------------
`define GSR_BIT_CONTROLLER 7
`define GSR_BIT_LISTENER 2
`define GSR_BIT_TALKER 1
`define GSR_BIT_DEVICE_CLEAR 5
`define GSR_BIT_TRIGGER 1
`define GSR_BIT_SERVICE_REQ 6
`define GSR_BIT_LOCKOUT 5
`define GSR_BIT_REMOTE 4
`define GSR_BIT_ADDR_CHANGE 0
`define GSR_BIT_TERM_LEN 1
`define GSR_BIT_TERM_EOI 0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define GSR_RST_IO_TIMEOUT 16'h2710
`define GSR_RST_DMA_TIMEOUT 16'h2710
`define GSR_RST_MASK 8'h00
`endif

// File: design/gsr_pkg.sv
/*
  Types of the bus status reporting block.
  Assumes the register header is included by the design file.
*/
package gsr_pkg;
  typedef logic [7:0] gsr_byte_t;
  typedef logic [15:0] gsr_term_t;
  typedef logic [31:0] gsr_word_t;
  typedef logic [11:0] gsr_addr_t;
endpackage

// File: design/gsr_status.sv
/*
  Status reporting register bank of a bus interface board: address status,
  two read-to-clear event registers, terminator packing, timeout values.
  Assumes bus state inputs arrive asynchronously from the bus interface and
  an APB master on REF_CLK.
*/
`timescale 1ns/100ps
`include "gsr_regs.svh"

module gsr_status #(
  parameter int NUM_TERMS = 4
) (
  input wire logic REF_CLK, // 10 MHz clock
  input wire logic RST_N, // Synchronous reset
  input wire gsr_pkg::gsr_addr_t PADDR, // APB address
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB enable
  input wire logic PWRITE, // APB direction
  input wire gsr_pkg::gsr_word_t PWDATA, // APB write data
  output gsr_pkg::gsr_word_t PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error
  input wire logic CONTROLLER_IN, // Active controller state
  input wire logic TALKER_IN, // Addressed as talker
  input wire logic LISTENER_IN, // Addressed as listener
  input wire logic TRIGGER_IN, // Group execute trigger received
  input wire logic DEVICE_CLEAR_IN, // Device clear received
  input wire logic SERVICE_REQ_IN, // Service request line
  input wire logic LOCKOUT_IN, // Local lockout state
  input wire logic REMOTE_IN, // Remote state
  output logic IRQ // Level interrupt
);
  import gsr_pkg::*;

  initial
  begin
    if (NUM_TERMS < 1 || NUM_TERMS > 4)
      $error("NUM_TERMS must be 1 to 4");
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [7:0] raw_in;
  logic [7:0] sync_a;
  logic [7:0] sync_b;
  logic [7:0] sync_prev;
  assign raw_in = {CONTROLLER_IN, TALKER_IN, LISTENER_IN, TRIGGER_IN,
                   DEVICE_CLEAR_IN, SERVICE_REQ_IN, LOCKOUT_IN, REMOTE_IN};

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      sync_a <= 8'h00;
      sync_b <= 8'h00;
      sync_prev <= 8'h00;
    end
    else
    begin
      sync_a <= raw_in;
      sync_b <= sync_a;
      sync_prev <= sync_b;
    end
  end

  logic ctl;
  logic tlk;
  logic lsn;
  assign ctl = sync_b[7];
  assign tlk = sync_b[6];
  assign lsn = sync_b[5];

  logic trig_rise;
  logic dcl_rise;
  logic srq_rise;
  logic lok_rise;
  logic rem_rise;
  logic adr_chg;
  assign trig_rise = sync_b[4] & ~sync_prev[4];
  assign dcl_rise = sync_b[3] & ~sync_prev[3];
  assign srq_rise = sync_b[2] & ~sync_prev[2];
  assign lok_rise = sync_b[1] & ~sync_prev[1];
  assign rem_rise = sync_b[0] & ~sync_prev[0];
  assign adr_chg = sync_b[7:5] != sync_prev[7:5];

  // ----------------------------------------
  // Address status byte
  // ----------------------------------------
  gsr_byte_t addr_status;
  always_comb
  begin
    addr_status = 8'h00;
    addr_status[`GSR_BIT_CONTROLLER] = ctl;
    addr_status[`GSR_BIT_LISTENER] = lsn;
    addr_status[`GSR_BIT_TALKER] = tlk;
  end

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic access;
  logic rd_one;
  logic rd_two;
  logic wr;
  assign access = PSEL & PENABLE;
  assign wr = access & PWRITE;
  assign rd_one = access & ~PWRITE & (PADDR == `GSR_OFF_EVENT_ONE);
  assign rd_two = access & ~PWRITE & (PADDR == `GSR_OFF_EVENT_TWO);
  assign PREADY = 1'b1;

  // ----------------------------------------
  // Event registers
  // ----------------------------------------
  gsr_byte_t bus_event_status_one;
  gsr_byte_t bus_event_status_two;
  gsr_byte_t set_one;
  gsr_byte_t set_two;
  always_comb
  begin
    set_one = 8'h00;
    set_two = 8'h00;
    set_one[`GSR_BIT_TRIGGER] = trig_rise & ~ctl;
    set_one[`GSR_BIT_DEVICE_CLEAR] = dcl_rise;
    set_two[`GSR_BIT_SERVICE_REQ] = srq_rise & ctl;
    set_two[`GSR_BIT_LOCKOUT] = lok_rise & ~ctl;
    set_two[`GSR_BIT_REMOTE] = rem_rise & ~ctl;
    set_two[`GSR_BIT_ADDR_CHANGE] = adr_chg;
  end

  // A set in the same cycle as the clearing read survives so no event is lost
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      bus_event_status_one <= 8'h00;
      bus_event_status_two <= 8'h00;
    end
    else
    begin
      bus_event_status_one <= (rd_one ? 8'h00 : bus_event_status_one) | set_one;
      bus_event_status_two <= (rd_two ? 8'h00 : bus_event_status_two) | set_two;
    end
  end

  // ----------------------------------------
  // Software-written settings
  // ----------------------------------------
  gsr_term_t out_term [NUM_TERMS];
  gsr_byte_t in_term [NUM_TERMS];
  logic [1:0] term_flags [NUM_TERMS];
  gsr_term_t io_timeout;
  gsr_term_t dma_timeout;
  gsr_byte_t mask_one;
  gsr_byte_t mask_two;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      io_timeout <= `GSR_RST_IO_TIMEOUT;
      dma_timeout <= `GSR_RST_DMA_TIMEOUT;
      mask_one <= `GSR_RST_MASK;
      mask_two <= `GSR_RST_MASK;
    end
    else if (wr)
    begin
      case (PADDR)
        `GSR_OFF_IO_TIMEOUT: io_timeout <= PWDATA[15:0];
        `GSR_OFF_DMA_TIMEOUT: dma_timeout <= PWDATA[15:0];
        `GSR_OFF_MASK_ONE: mask_one <= PWDATA[7:0];
        `GSR_OFF_MASK_TWO: mask_two <= PWDATA[7:0];
        default: ;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TERMS; gi++)
    begin : g_term
      always_ff @(posedge REF_CLK)
      begin
        if (!RST_N)
        begin
          out_term[gi] <= 16'h0000;
          in_term[gi] <= 8'h00;
          term_flags[gi] <= 2'b00;
        end
        else if (wr && PADDR == `GSR_OFF_OUT_TERM0 + 12'(4 * gi))
          out_term[gi] <= PWDATA[15:0];
        else if (wr && PADDR == `GSR_OFF_IN_TERM0 + 12'(4 * gi))
          in_term[gi] <= PWDATA[7:0];
        else if (wr && PADDR == `GSR_OFF_TERM_FLAGS0 + 12'(4 * gi))
          term_flags[gi] <= PWDATA[1:0];
      end
    end
  endgenerate

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // One-byte terminator shows only its last character; upper byte forced to zero
  function automatic gsr_term_t pack_out(input gsr_term_t t, input logic two);
    pack_out = two ? t : {8'h00, t[7:0]};
  endfunction

  gsr_word_t next_rdata;
  logic next_err;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (PADDR)
      `GSR_OFF_ADDR_STATUS: next_rdata = {24'h00_0000, addr_status};
      `GSR_OFF_EVENT_ONE: next_rdata = {24'h00_0000, bus_event_status_one};
      `GSR_OFF_EVENT_TWO: next_rdata = {24'h00_0000, bus_event_status_two};
      `GSR_OFF_IO_TIMEOUT: next_rdata = {16'h0000, io_timeout};
      `GSR_OFF_DMA_TIMEOUT: next_rdata = {16'h0000, dma_timeout};
      `GSR_OFF_MASK_ONE: next_rdata = {24'h00_0000, mask_one};
      `GSR_OFF_MASK_TWO: next_rdata = {24'h00_0000, mask_two};
      default: next_err = 1'b1;
    endcase
    for (int i = 0; i < NUM_TERMS; i++)
    begin
      if (PADDR == `GSR_OFF_OUT_TERM0 + 12'(4 * i))
      begin
        next_rdata = {16'h0000, pack_out(out_term[i], term_flags[i][`GSR_BIT_TERM_LEN])};
        next_err = 1'b0;
      end
      if (PADDR == `GSR_OFF_IN_TERM0 + 12'(4 * i))
      begin
        next_rdata = {24'h00_0000, in_term[i]};
        next_err = 1'b0;
      end
      if (PADDR == `GSR_OFF_TERM_FLAGS0 + 12'(4 * i))
      begin
        next_rdata = {30'h0000_0000, term_flags[i]};
        next_err = 1'b0;
      end
    end
  end

  assign PRDATA = access ? next_rdata : 32'h0000_0000;
  assign PSLVERR = access & next_err;

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      IRQ <= 1'b0;
    else
      IRQ <= |((bus_event_status_one | set_one) & ~(rd_one ? 8'hFF : 8'h00) & mask_one)
           | |((bus_event_status_two | set_two) & ~(rd_two ? 8'hFF : 8'h00) & mask_two);
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_talker_tracks: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    addr_status[`GSR_BIT_TALKER] == sync_b[6]) else $error("talker flag wrong");
  a_ctl_bit: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    addr_status[`GSR_BIT_CONTROLLER] == sync_b[7] && addr_status[`GSR_BIT_LISTENER] == sync_b[5])
    else $error("address status layout wrong");
  a_trigger_sets: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    trig_rise && !ctl |=> bus_event_status_one[`GSR_BIT_TRIGGER]) else $error("trigger not latched");
  a_dclear_sets: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    dcl_rise |=> bus_event_status_one[`GSR_BIT_DEVICE_CLEAR]) else $error("device clear not latched");
  a_srq_ctl_only: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $rose(bus_event_status_two[`GSR_BIT_SERVICE_REQ]) |-> $past(ctl)) else $error("srq outside controller");
  a_lockout_dev: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    lok_rise && !ctl |=> bus_event_status_two[`GSR_BIT_LOCKOUT]) else $error("lockout not latched");
  a_remote_dev: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $rose(bus_event_status_two[`GSR_BIT_REMOTE]) |-> $past(!ctl)) else $error("remote in controller");
  a_addr_change: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    adr_chg |=> bus_event_status_two[`GSR_BIT_ADDR_CHANGE]) else $error("address change lost");
  a_read_clears: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    rd_two |=> bus_event_status_two == $past(set_two)) else $error("read did not clear");
  a_flag_holds: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    bus_event_status_one[`GSR_BIT_DEVICE_CLEAR] && !rd_one |=> bus_event_status_one[`GSR_BIT_DEVICE_CLEAR])
    else $error("flag dropped");
endmodule // gsr_status

// File: verif/gsr_bus_model.sv
/*
  Bus side model: instruments and controller as seen through the bus state lines.
  Assumes the bench asks for a new bus state no more often than every few cycles.
*/
`timescale 1ns/100ps
module gsr_bus_model (
  input wire logic clk, // Reference clock
  input wire logic [7:0] want, // Requested bus state
  output logic [7:0] lines // Bus state toward the block
);
  // ----------------------------------------
  // Bus state
  // ----------------------------------------
  // Levels change only at an edge and then hold, so the block sees whole cycles
  always_ff @(posedge clk)
  begin
    lines <= want;
  end
endmodule // gsr_bus_model

// File: verif/gsr_status_tb_top.sv
/*
  Self-checking bench of the status reporting block.
  Assumes the block answers APB with no wait state or later, and latches bus events.
*/
`timescale 1ns/100ps
`include "gsr_regs.svh"
module gsr_status_tb_top;
  import gsr_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  gsr_addr_t paddr = 12'h000;
  gsr_word_t pwdata = 32'h0000_0000, prdata, d;
  logic pready, pslverr, irq;
  logic [7:0] want = 8'h00, lines;
  int err_count = 0, n_compared = 0;
  gsr_word_t exp_q[$], msk_q[$];
  logic err_q[$];
  // ----------------------------------------
  // Design and bus model
  // ----------------------------------------
  gsr_status uut (.REF_CLK(ref_clk), .RST_N(rst_n), .PADDR(paddr), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CONTROLLER_IN(lines[0]), .TALKER_IN(lines[1]), .LISTENER_IN(lines[2]), .TRIGGER_IN(lines[3]),
    .DEVICE_CLEAR_IN(lines[4]), .SERVICE_REQ_IN(lines[5]), .LOCKOUT_IN(lines[6]), .REMOTE_IN(lines[7]),
    .IRQ(irq));
  gsr_bus_model bus (.clk(ref_clk), .want(want), .lines(lines));
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic check(input gsr_word_t seen, input gsr_word_t expv);
    n_compared++;
    if (seen !== expv)
    begin
      err_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, seen, expv);
    end
  endtask
  task automatic end_sim();
    // A transfer that never completed leaves its note behind
    if (exp_q.size() != 0)
      err_count++;
    if (err_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Don't-care bits are masked off before comparing
  always @(posedge ref_clk)
  begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
    begin
      check(prdata & msk_q[0], exp_q.pop_front());
      check({31'h0, pslverr}, {31'h0, err_q.pop_front()});
      void'(msk_q.pop_front());
    end
  end
  // ----------------------------------------
  // Bus master
  // ----------------------------------------
  task automatic apb(input gsr_addr_t a, input logic w, input gsr_word_t wd);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input gsr_addr_t a, input gsr_word_t e, input gsr_word_t m, input logic er);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    err_q.push_back(er);
    apb(a, 1'b0, 32'h0000_0000);
  endtask
  task automatic wr(input gsr_addr_t a, input gsr_word_t wd);
    exp_q.push_back(32'h0000_0000);
    msk_q.push_back(32'h0000_0000);
    err_q.push_back(1'b0);
    apb(a, 1'b1, wd);
  endtask
  task automatic go(input logic [7:0] v);
    @(posedge ref_clk);
    want <= v;
    repeat (6) @(posedge ref_clk);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    end_sim();
  end
  initial
  begin
    void'($urandom(32'hc85e52da));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`GSR_OFF_ADDR_STATUS, 32'h0, 32'h86, 1'b0);
    rd(`GSR_OFF_IO_TIMEOUT, 32'h2710, 32'hffff_ffff, 1'b0);
    rd(`GSR_OFF_MASK_TWO, 32'h0, 32'hff, 1'b0);
    rd(12'h0FC, 32'h0, 32'hffff_ffff, 1'b1);
    go(8'h02);
    rd(`GSR_OFF_ADDR_STATUS, 32'h02, 32'h86, 1'b0);
    rd(`GSR_OFF_EVENT_TWO, 32'h01, 32'h71, 1'b0);
    rd(`GSR_OFF_EVENT_TWO, 32'h00, 32'h71, 1'b0);
    go(8'h07);
    rd(`GSR_OFF_ADDR_STATUS, 32'h86, 32'h86, 1'b0);
    go(8'h00);
    rd(`GSR_OFF_EVENT_TWO, 32'h01, 32'h71, 1'b0);
    // Event one is read only once its events have settled
    wr(`GSR_OFF_MASK_ONE, 32'h20);
    go(8'h18);
    // Look at the registered interrupt between edges, never at the edge that launches it
    @(negedge ref_clk);
    check({31'h0, irq}, 32'h1);
    go(8'h00);
    rd(`GSR_OFF_EVENT_ONE, 32'h22, 32'h22, 1'b0);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check({31'h0, irq}, 32'h0);
    rd(`GSR_OFF_EVENT_ONE, 32'h00, 32'h22, 1'b0);
    go(8'hC0);
    go(8'h00);
    rd(`GSR_OFF_EVENT_TWO, 32'h30, 32'h71, 1'b0);
    go(8'h01);
    go(8'hE9);
    go(8'h01);
    rd(`GSR_OFF_EVENT_ONE, 32'h00, 32'h22, 1'b0);
    rd(`GSR_OFF_EVENT_TWO, 32'h41, 32'h71, 1'b0);
    go(8'h00);
    go(8'h20);
    go(8'h00);
    rd(`GSR_OFF_EVENT_TWO, 32'h01, 32'h71, 1'b0);
    for (int i = 0; i < 2; i++)
    begin
      d = (i == 0) ? $urandom : 32'h0000_ffff;
      wr(i ? `GSR_OFF_DMA_TIMEOUT : `GSR_OFF_IO_TIMEOUT, d);
      rd(i ? `GSR_OFF_DMA_TIMEOUT : `GSR_OFF_IO_TIMEOUT, d & 32'hffff, 32'hffff_ffff, 1'b0);
    end
    for (int n = 0; n < 4; n++)
    begin
      d = $urandom & 32'hffff;
      wr(`GSR_OFF_OUT_TERM0 + 12'(4 * n), d);
      wr(`GSR_OFF_TERM_FLAGS0 + 12'(4 * n), n);
      wr(`GSR_OFF_IN_TERM0 + 12'(4 * n), d);
      rd(`GSR_OFF_OUT_TERM0 + 12'(4 * n), n[1] ? d : d & 32'hff, 32'hffff_ffff, 1'b0);
      rd(`GSR_OFF_TERM_FLAGS0 + 12'(4 * n), n, 32'h3, 1'b0);
      rd(`GSR_OFF_IN_TERM0 + 12'(4 * n), d & 32'hff, 32'hffff_ffff, 1'b0);
    end
    repeat (2) @(posedge ref_clk);
    end_sim();
  end
endmodule // gsr_status_tb_top
